// >>> design/ccs_pkg.sv
// package of constants for the controller status register upper bank
// Behaviour
// - bit 4 high while card present
// - bit 5 high when buffer can transfer
// - bit 6 shows buffer direction, write high
// - bit 7 high after configuration complete
// - bit 8 high when command accepted
// - bit 9 reflects autostart pin
// - control bit overrides autostart pin
// - bits 13-15 report image select pins
// - control field replaces image select pins
// - bit 17 mirrors card busy
// - bit 18 mirrors card ready
// - bit 19 mirrors card write fault
// - bit 20 mirrors card seek done
// - bit 21 mirrors card data request
// - bit 22 mirrors card corrected error
// - bit 23 mirrors card error
// - status at byte 04h-07h, word 02h-03h
package ccs_pkg;
    // ****************************************
    // status register addresses
    // ****************************************
    localparam logic [6:0] CCS_BYTE_ADDR_LO = 7'h04; // first byte lane of status
    localparam logic [6:0] CCS_BYTE_ADDR_HI = 7'h07; // last byte lane of status
    localparam logic [6:0] CCS_WORD_ADDR_LO = 7'h02; // low half word of status
    localparam logic [6:0] CCS_WORD_ADDR_HI = 7'h03; // high half word of status
    // ****************************************
    // status field positions
    // ****************************************
    localparam int CCS_CARD_PRESENT_BIT = 4;
    localparam int CCS_BUFFER_READY_BIT = 5;
    localparam int CCS_BUFFER_DIRECTION_BIT = 6;
    localparam int CCS_CONFIG_COMPLETE_BIT = 7;
    localparam int CCS_CARD_CMD_READY_BIT = 8;
    localparam int CCS_AUTOSTART_PIN_BIT = 9;
    localparam int CCS_IMAGE_SELECT_LSB = 13;
    localparam int CCS_IMAGE_SELECT_W = 3;
    localparam int CCS_CARD_BUSY_BIT = 17;
    localparam int CCS_MIRROR_LSB = 18;
    localparam int CCS_MIRROR_W = 6;
    // ****************************************
    // ata status bit positions in the card's status byte
    // ****************************************
    localparam int CCS_ATA_ERR = 0;
    localparam int CCS_ATA_CORR = 2;
    localparam int CCS_ATA_DRQ = 3;
    localparam int CCS_ATA_DSC = 4;
    localparam int CCS_ATA_DWF = 5;
    localparam int CCS_ATA_RDY = 6;
    localparam int CCS_ATA_BSY = 7;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] CCS_ATA_RESET = 8'h80; // card assumed busy until first poll
    localparam logic [31:0] CCS_STATUS_RESET = 32'h0000_0000;
endpackage

// >>> design/ccs_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ccs_pin_sync
    import ccs_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    // ****************************************
    // synchroniser chain
    // ****************************************
    logic [WIDTH-1:0] meta_r; // first stage, read only by second
    logic [WIDTH-1:0] sync2_r; // second stage
    logic [WIDTH-1:0] sync3_r; // third stage

    // shift chain
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            meta_r <= pin_in;
            sync2_r <= meta_r;
            sync3_r <= sync2_r;
        end
    end

    // a change counts only once stages two and three agree, per bit
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_out[g] <= 1'b0;
                end else if (sync2_r[g] == sync3_r[g]) begin
                    pin_out[g] <= sync3_r[g];
                end
            end
        end
    endgenerate
endmodule

// >>> design/ccs_status_upper.sv
// upper status register bank: card, buffer, configuration and ata mirror status
`timescale 1ns/1ps
module ccs_status_upper
    import ccs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    // parallel host bus
    input wire logic [6:0] host_addr,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic bus_word_mode,
    output logic [15:0] host_rdata,
    output logic host_rdata_oe,
    // device pins
    input wire logic card_present_pin_n,
    input wire logic autostart_pin,
    input wire logic image_select_pin0,
    input wire logic image_select_pin1,
    input wire logic image_select_pin2,
    // control register fields
    input wire logic autostart_override_en,
    input wire logic autostart_override,
    input wire logic image_select_override_en,
    input wire logic [2:0] image_select_override,
    // internal engine state, same clock
    input wire logic buffer_ready,
    input wire logic buffer_direction,
    input wire logic config_complete,
    input wire logic card_cmd_ready,
    input wire logic card_poll_valid,
    input wire logic [7:0] card_ata_status,
    // lower status bits from lock and error logic
    input wire logic [3:0] status_lower,
    // effective configuration selections
    output logic config_autostart,
    output logic [2:0] image_select,
    output logic [31:0] controller_status
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_r; // first reset stage
    logic rst_sync_n_r; // released reset used by the bank

    // release reset through two flip-flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // ****************************************
    // pin sampling
    // ****************************************
    logic [4:0] pins_raw; // raw pins
    logic [4:0] pins_sync; // filtered pins

    assign pins_raw = {image_select_pin2, image_select_pin1, image_select_pin0,
                       autostart_pin, card_present_pin_n};

    // pins arrive asynchronously, so filter them before use
    ccs_pin_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_sync_n_r),
        .pin_in(pins_raw),
        .pin_out(pins_sync)
    );

    logic card_present; // card detect, active high
    logic autostart_pin_state; // sampled autostart pin
    logic [2:0] image_select_pins; // sampled image select pins

    assign card_present = ~pins_sync[0];
    assign autostart_pin_state = pins_sync[1];
    assign image_select_pins = pins_sync[4:2];

    // ****************************************
    // ata mirror
    // ****************************************
    logic [7:0] ata_r; // last polled card status byte

    // refresh only on a poll with a card in; stale values stay until the next poll or card removal
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            ata_r <= CCS_ATA_RESET;
        end else if (!card_present) begin
            ata_r <= CCS_ATA_RESET; // no card, nothing trustworthy to show
        end else if (card_poll_valid) begin
            ata_r <= card_ata_status;
        end
    end

    // ****************************************
    // override selection
    // ****************************************
    // control register bit wins over the pin when enabled
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            config_autostart <= 1'b0;
        end else if (autostart_override_en) begin
            config_autostart <= autostart_override;
        end else begin
            config_autostart <= autostart_pin_state;
        end
    end

    // image offset from control field or pins
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            image_select <= 3'h0;
        end else if (image_select_override_en) begin
            image_select <= image_select_override;
        end else begin
            image_select <= image_select_pins;
        end
    end

    // ****************************************
    // status assembly
    // ****************************************
    logic [31:0] status_nxt; // next status word

    // reserved bits are left at zero by the default assignment
    always_comb begin
        status_nxt = CCS_STATUS_RESET;
        status_nxt[3:0] = status_lower;
        status_nxt[CCS_CARD_PRESENT_BIT] = card_present;
        // buffer ready only meaningful with a card attached
        status_nxt[CCS_BUFFER_READY_BIT] = buffer_ready;
        status_nxt[CCS_BUFFER_DIRECTION_BIT] = buffer_direction;
        status_nxt[CCS_CONFIG_COMPLETE_BIT] = config_complete;
        status_nxt[CCS_CARD_CMD_READY_BIT] = card_cmd_ready;
        status_nxt[CCS_AUTOSTART_PIN_BIT] = autostart_pin_state;
        status_nxt[CCS_IMAGE_SELECT_LSB +: CCS_IMAGE_SELECT_W] = image_select_pins;
        // bits 18-23 remain driven while busy; the host must discard them
        status_nxt[CCS_CARD_BUSY_BIT] = ata_r[CCS_ATA_BSY];
        status_nxt[CCS_MIRROR_LSB + 0] = ata_r[CCS_ATA_RDY];
        status_nxt[CCS_MIRROR_LSB + 1] = ata_r[CCS_ATA_DWF];
        status_nxt[CCS_MIRROR_LSB + 2] = ata_r[CCS_ATA_DSC];
        status_nxt[CCS_MIRROR_LSB + 3] = ata_r[CCS_ATA_DRQ];
        status_nxt[CCS_MIRROR_LSB + 4] = ata_r[CCS_ATA_CORR];
        status_nxt[CCS_MIRROR_LSB + 5] = ata_r[CCS_ATA_ERR];
    end

    // status register, read-only: no write path exists
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            controller_status <= CCS_STATUS_RESET;
        end else begin
            controller_status <= status_nxt;
        end
    end

    // ****************************************
    // host read path
    // ****************************************
    // decode: returns lane select, 3'b1xx meaning no hit
    function automatic logic [2:0] ccs_decode(input logic [6:0] a, input logic wm);
        logic [2:0] r;
        r = 3'h4;
        if (!wm && a >= CCS_BYTE_ADDR_LO && a <= CCS_BYTE_ADDR_HI) begin
            r = {1'b0, a[1:0]};
        end else if (wm && a >= CCS_WORD_ADDR_LO && a <= CCS_WORD_ADDR_HI) begin
            r = {1'b0, 1'b0, a[0]};
        end
        return r;
    endfunction

    logic [2:0] lane; // decoded lane
    logic rd_hit; // read of status this cycle
    logic [15:0] rdata_nxt; // next read data

    assign lane = ccs_decode(host_addr, bus_word_mode);
    // a strobe pair with write also low is not a clean read, so it is refused
    assign rd_hit = !host_cs_n && !host_rd_n && host_wr_n && !lane[2];

    // select byte or half word; writes are simply ignored
    always_comb begin
        rdata_nxt = 16'h0000;
        if (rd_hit) begin
            if (bus_word_mode) begin
                rdata_nxt = lane[0] ? controller_status[31:16] : controller_status[15:0];
            end else begin
                case (lane[1:0])
                    2'h0: rdata_nxt = {8'h00, controller_status[7:0]};
                    2'h1: rdata_nxt = {8'h00, controller_status[15:8]};
                    2'h2: rdata_nxt = {8'h00, controller_status[23:16]};
                    2'h3: rdata_nxt = {8'h00, controller_status[31:24]};
                    default: rdata_nxt = 16'h0000;
                endcase
            end
        end
    end

    // registered read data, one cycle after the strobe is seen
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            host_rdata <= 16'h0000;
            host_rdata_oe <= 1'b0;
        end else begin
            host_rdata <= rdata_nxt;
            host_rdata_oe <= rd_hit;
        end
    end
endmodule

// >>> dv/ccs_status_upper_monitor.sv
// checker for the upper status register bank
`timescale 1ns/1ps
module ccs_status_upper_monitor
    import ccs_pkg::*;
(
    input wire logic core_clk, rst_n, host_cs_n, host_rd_n, bus_word_mode,
    input wire logic [6:0] host_addr,
    input wire logic [15:0] host_rdata,
    input wire logic host_rdata_oe, buffer_ready, buffer_direction, config_complete,
    input wire logic card_cmd_ready, card_poll_valid, config_autostart,
    input wire logic autostart_override_en, autostart_override, image_select_override_en,
    input wire logic [2:0] image_select_override, image_select,
    input wire logic [7:0] card_ata_status,
    input wire logic [3:0] status_lower,
    input wire logic [31:0] controller_status
);
    logic [2:0] up_r; // edges since release, covers the internal reset sync
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) up_r <= 3'h0;
        else if (up_r != 3'h7) up_r <= up_r + 3'h1;
    end
    wire ok = up_r == 3'h7;
    wire hit = !host_cs_n && !host_rd_n && (bus_word_mode ?
        host_addr inside {[CCS_WORD_ADDR_LO:CCS_WORD_ADDR_HI]} : host_addr inside {[CCS_BYTE_ADDR_LO:CCS_BYTE_ADDR_HI]});
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_poll;
        ok && card_poll_valid && controller_status[4] ##1 !card_poll_valid ##1 controller_status[4];
    endsequence
    a_read_answer: assert property (ok && hit |=> host_rdata_oe) else $error("read not answered");
    a_refused_quiet: assert property (ok && !hit |=> !host_rdata_oe && host_rdata == 16'h0000)
        else $error("answer without hit");
    a_byte_lane: assert property (ok && hit && !bus_word_mode |=> host_rdata[15:8] == 8'h00)
        else $error("upper lane in byte mode");
    a_engine_bits: assert property (ok |=> controller_status[8:5] ==
        $past({card_cmd_ready, config_complete, buffer_direction, buffer_ready}))
        else $error("engine bits wrong");
    a_reserved_zero: assert property (ok |-> controller_status[31:24] == 8'h00 && controller_status[16] == 1'b0
        && controller_status[12:10] == 3'h0) else $error("reserved bit set");
    a_mirror_poll: assert property (s_poll |-> controller_status[23:17] == $past({card_ata_status[0],
        card_ata_status[2], card_ata_status[3], card_ata_status[4], card_ata_status[5], card_ata_status[6],
        card_ata_status[7]}, 2)) else $error("mirror wrong");
    a_autostart_sel: assert property (ok && autostart_override_en |=> config_autostart == $past(autostart_override))
        else $error("autostart override ignored");
    a_image_sel: assert property (ok && image_select_override_en |=> image_select == $past(image_select_override))
        else $error("image override ignored");
    a_lower_pass: assert property (ok |=> controller_status[3:0] == $past(status_lower))
        else $error("lower bits wrong");
endmodule
bind ccs_status_upper ccs_status_upper_monitor mon_u (.*);

// >>> dv/ccs_host_model.sv
// host model driving the parallel status bus
`timescale 1ns/1ps
module ccs_host_model (
    input wire logic core_clk,
    input wire logic [15:0] host_rdata,
    input wire logic host_rdata_oe,
    output logic [6:0] host_addr,
    output logic host_cs_n, host_rd_n, host_wr_n, bus_word_mode
);
    initial begin
        host_addr = 7'h55;
        {host_cs_n, host_rd_n, host_wr_n, bus_word_mode} = 4'hE;
    end
    // one access, strobes held until the registered answer has been seen
    task automatic acc(input logic wm, input logic [6:0] a, input logic rd, output logic oe, output logic [15:0] d);
        @(posedge core_clk);
        #1 {bus_word_mode, host_addr, host_cs_n, host_rd_n, host_wr_n} = {wm, a, 1'b0, !rd, rd};
        repeat (2) @(posedge core_clk);
        #1 {oe, d} = {host_rdata_oe, host_rdata};
        {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
        host_addr = ~a; // a released bus never keeps the last address
    endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the upper status register bank
`timescale 1ns/1ps
module testbench;
    import ccs_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, poll = 1'b0, oe;
    logic [31:0] v = 32'h0000_0000, st;
    logic [15:0] d, host_rdata;
    logic [6:0] host_addr;
    logic host_cs_n, host_rd_n, host_wr_n, bus_word_mode, host_rdata_oe, card_present_pin_n, autostart_pin;
    logic image_select_pin0, image_select_pin1, image_select_pin2, autostart_override_en, autostart_override;
    logic image_select_override_en, buffer_ready, buffer_direction, config_complete, card_cmd_ready, config_autostart;
    logic [2:0] image_select_override, image_select;
    logic [7:0] card_ata_status;
    logic [3:0] status_lower;
    logic [31:0] controller_status;
    logic [8:0] bad [4] = '{9'h108, 9'h004, 9'h184, 9'h103}; // {word mode, read, address}, all refused
    int error_cnt = 0, checks = 0, cyc = 0;
    always #12.5 core_clk = ~core_clk;
    // every control and pin input follows one stimulus word
    assign {status_lower, card_ata_status, card_cmd_ready, config_complete, buffer_direction, buffer_ready,
        image_select_override, image_select_override_en, autostart_override, autostart_override_en,
        image_select_pin2, image_select_pin1, image_select_pin0, autostart_pin, card_present_pin_n} = v[26:0];
    ccs_host_model host_u (.core_clk(core_clk), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
        .host_addr(host_addr), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
        .bus_word_mode(bus_word_mode));
    ccs_status_upper dut_u (.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr), .host_cs_n(host_cs_n),
        .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .bus_word_mode(bus_word_mode), .host_rdata(host_rdata),
        .host_rdata_oe(host_rdata_oe), .card_present_pin_n(card_present_pin_n), .autostart_pin(autostart_pin),
        .image_select_pin0(image_select_pin0), .image_select_pin1(image_select_pin1),
        .image_select_pin2(image_select_pin2), .autostart_override_en(autostart_override_en),
        .autostart_override(autostart_override), .image_select_override_en(image_select_override_en),
        .image_select_override(image_select_override), .buffer_ready(buffer_ready),
        .buffer_direction(buffer_direction), .config_complete(config_complete), .card_cmd_ready(card_cmd_ready),
        .card_poll_valid(poll), .card_ata_status(card_ata_status), .status_lower(status_lower),
        .config_autostart(config_autostart), .image_select(image_select), .controller_status(controller_status));
    // status expected for a stimulus word; an absent card reads as busy
    function automatic logic [31:0] exp_st(input logic [31:0] s);
        logic [7:0] a;
        a = s[0] ? CCS_ATA_RESET : s[22:15];
        return {8'h00, a[0], a[2], a[3], a[4], a[5], a[6], a[7], 1'b0, s[4:2], 3'h0, s[1], s[14:11], ~s[0], s[26:23]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        #1 chk(controller_status, CCS_STATUS_RESET);
        rst_n = 1'b1;
        repeat (8) @(posedge core_clk);
        #1 chk(controller_status, 32'h0002_0010);
        for (int i = 0; i < 8; i++) begin
            v = 32'h9E37_79B9 * (i + 1);
            st = exp_st(v);
            repeat (8) @(posedge core_clk);
            #1 poll = 1'b1;
            @(posedge core_clk);
            #1 poll = 1'b0;
            repeat (3) @(posedge core_clk);
            #1 chk(controller_status, st);
            chk(32'(config_autostart), 32'(v[5] ? v[6] : v[1]));
            chk(32'(image_select), 32'(v[7] ? v[10:8] : v[4:2]));
            for (int k = 0; k < 4; k++) begin
                host_u.acc(1'b0, 7'(4 + k), 1'b1, oe, d);
                chk({oe, d}, {1'b1, 8'h00, st[8*k +: 8]});
            end
            for (int k = 0; k < 2; k++) begin
                host_u.acc(1'b1, 7'(2 + k), 1'b1, oe, d);
                chk({oe, d}, {1'b1, st[16*k +: 16]});
            end
            for (int k = 0; k < 4; k++) begin
                host_u.acc(bad[k][8], bad[k][6:0], bad[k][7], oe, d);
                chk({oe, d}, 32'h0000_0000);
            end
            chk(controller_status, st);
            @(posedge core_clk);
            #1;
        end
        summarize();
    end
endmodule
